// file: exec_pkg.sv
// Opcodes, flag positions, reset values and state types of the logic/output executor
package exec_pkg;

  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [7:0] OP_OR_MEM  = 8'hb6;
  localparam logic [7:0] OP_OR_IMM  = 8'hf6;
  localparam logic [7:0] OP_OR_HI   = 8'hb4;
  localparam logic [7:0] OP_OR_LO   = 8'hb5;
  localparam logic [4:0] OP_OR_REG  = 5'h16;
  localparam logic [2:0] SEL_B      = 3'h0;
  localparam logic [2:0] SEL_C      = 3'h1;
  localparam logic [2:0] SEL_D      = 3'h2;
  localparam logic [2:0] SEL_E      = 3'h3;
  localparam logic [2:0] SEL_H      = 3'h4;
  localparam logic [2:0] SEL_L      = 3'h5;
  localparam logic [2:0] SEL_MEM    = 3'h6;
  localparam logic [2:0] SEL_A      = 3'h7;
  localparam logic [7:0] PFX_SHORT  = 8'h52;
  localparam logic [7:0] PFX_LONG   = 8'h49;
  localparam logic [7:0] PFX_FIRST  = 8'hdd;
  localparam logic [7:0] PFX_SECOND = 8'hfd;
  localparam logic [7:0] PFX_EXT    = 8'hed;
  localparam logic [7:0] OP_DUAL    = 8'hbc;
  localparam logic [7:0] OP_PZ      = 8'h8b;
  localparam logic [7:0] OP_PZ_REP  = 8'h9b;
  localparam logic [7:0] OP_REP     = 8'hbb;

  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  localparam logic [23:0] RST_PC    = 24'h000000;
  localparam logic [23:0] RST_PAIR  = 24'h000000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  // Upper I/O address byte is don't-care for decoders; drive a fixed value
  localparam logic [7:0]  IO_UPPER  = 8'h00;

  typedef enum {
    ST_FETCH,
    ST_INDEX,
    ST_DISP,
    ST_OPND,
    ST_IMM,
    ST_EXT,
    ST_BLK_READ,
    ST_BLK_WRITE,
    ST_BLK_STEP
  } state_type;

  typedef enum {
    BLK_DUAL,
    BLK_PZ,
    BLK_PZ_REP,
    BLK_REP
  } blk_type;

endpackage : exec_pkg

// file: io_mem_model.sv
// Memory and I/O peripheral model on the far side of the executor
`timescale 1ns/1ps
module io_mem_model (
  input  wire logic        clk,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  input  wire logic [23:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr
);
  logic [7:0]  prog [0:255];
  logic [23:0] io_q [$];

  // Program in the bottom page, an address-derived pattern elsewhere
  function automatic logic [7:0] rd(input logic [23:0] a);
    if (a < 24'h000100)
      return prog[a[7:0]];
    return a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h5a;
  endfunction : rd

  // Outside read cycles the lines show garbage, so a stale byte cannot pass
  always_comb mem_rdata = mem_rd ? rd(mem_addr) : ~rd(mem_addr);

  // The decoder looks at the low 16 address bits only
  always @(posedge clk) begin
    if (io_wr === 1'b1)
      io_q.push_back({io_addr[15:0], io_wdata});
  end
endmodule : io_mem_model

// file: logic_or_and_block_output_exec.sv
// Executor for the idle instruction, accumulator OR forms and decrementing block output
// What this block does
// - Opcode 00 takes one cycle, only advances the program counter, keeps flags.
// - OR with byte at memory_pointer_pair is B6, 2 cycles, 3 when prefixed.
// - DD/FD then B4/B5 ORs an index half into A in 2 cycles.
// - DD/FD B6 d ORs byte at index plus signed d; 4 cycles, 5 prefixed.
// - F6 n ORs the immediate byte into A in 2 cycles.
// - B0-B5, B7 OR register B,C,D,E,H,L or A into A in one cycle.
// - OR sets S, Z, even parity; clears H, N and C.
// - Dual-decrement output writes byte to io_pointer_pair address, decrements three pairs.
// - Dual-decrement sets Z when count_pair-1 is 0, N from byte bit 7.
// - Dual-decrement is ED BC, 2+3*count_pair cycles, one more when prefixed.
// - Address bits 23:16 of I/O writes carry no meaning.
// - Page-zero outputs drive I/O address 15:8 zero, 7:0 from C.
// - ED 8B moves one byte in 5 cycles, decrements B, C, memory_pointer_pair.
// - Page-zero outputs set Z when B-1 is 0, N from byte bit 7.
// - ED 9B repeats the page-zero transfer until B reaches zero.
// - Repeating output writes to count_pair address, decrements B and memory_pointer_pair.
// - ED BB repeating output: Z when B-1 is 0, N from byte bit 7, other flags kept.
`timescale 1ns/1ps
module logic_or_and_block_output_exec
  import exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        long_address_mode,
  input  wire logic [7:0]  mem_rdata,
  output logic      [23:0] mem_addr,
  output logic             mem_rd,
  output logic      [23:0] io_addr,
  output logic      [7:0]  io_wdata,
  output logic             io_wr,
  output logic             instr_done,
  output logic      [23:0] pc,
  output logic      [7:0]  acc,
  output logic      [7:0]  flags
);

  regs_if rf ();

  reg_store u_store (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rf      (rf)
  );

  state_type   state;
  state_type   next_state;
  blk_type     blk;
  blk_type     next_blk;
  logic        pfx_short;
  logic        pfx_long;
  logic        idx_second;
  logic [23:0] op_addr;
  logic [7:0]  xfer;
  logic        next_pfx_short;
  logic        next_pfx_long;
  logic        next_idx_second;
  logic [23:0] next_op_addr;
  logic [7:0]  next_xfer;
  logic [23:0] next_pc;
  logic [23:0] next_mem_addr;
  logic        next_mem_rd;
  logic [23:0] next_io_addr;
  logic [7:0]  next_io_wdata;
  logic        next_io_wr;
  logic        next_instr_done;
  logic        wide;
  logic [23:0] idx_reg;
  logic [7:0]  reg_operand;
  logic [7:0]  b_dec;
  logic [7:0]  c_dec;
  logic [23:0] bc_dec;

  assign acc   = rf.a;
  assign flags = rf.f;

  // Pointer width for this instruction
  assign wide    = pfx_long | (~pfx_short & long_address_mode);
  assign idx_reg = idx_second ? rf.iy : rf.ix;
  assign b_dec   = rf.bc[15:8] - 8'h01;
  assign c_dec   = rf.bc[7:0] - 8'h01;

  function automatic logic [23:0] dec_ptr(input logic [23:0] v, input logic w);
    logic [15:0] low;
    low = v[15:0] - 16'h0001;
    // In 16-bit treatment the upper byte is held, so the pointer wraps in 64K
    dec_ptr = w ? (v - 24'h000001) : {v[23:16], low};
  endfunction : dec_ptr

  function automatic logic [7:0] or_flags(input logic [7:0] f, input logic [7:0] res);
    logic [7:0] nf;
    nf         = f;
    nf[FLAG_S]  = res[7];
    nf[FLAG_Z]  = (res == 8'h00);
    nf[FLAG_PV] = ~(^res);
    nf[FLAG_H]  = 1'b0;
    nf[FLAG_N]  = 1'b0;
    nf[FLAG_C]  = 1'b0;
    or_flags   = nf;
  endfunction : or_flags

  assign bc_dec = dec_ptr(rf.bc, wide);

  always_comb begin
    case (mem_rdata[2:0])
      SEL_B:   reg_operand = rf.bc[15:8];
      SEL_C:   reg_operand = rf.bc[7:0];
      SEL_D:   reg_operand = rf.de[15:8];
      SEL_E:   reg_operand = rf.de[7:0];
      SEL_H:   reg_operand = rf.hl[15:8];
      SEL_L:   reg_operand = rf.hl[7:0];
      SEL_A:   reg_operand = rf.a;
      default: reg_operand = 8'h00;
    endcase
  end

  always_comb begin
    logic finish;
    logic [7:0] res;
    finish          = 1'b0;
    res             = 8'h00;
    next_state      = state;
    next_blk        = blk;
    next_pfx_short  = pfx_short;
    next_pfx_long   = pfx_long;
    next_idx_second = idx_second;
    next_op_addr    = op_addr;
    next_xfer       = xfer;
    next_pc         = pc;
    next_io_addr    = io_addr;
    next_io_wdata   = io_wdata;
    next_io_wr      = 1'b0;
    rf.next_a       = rf.a;
    rf.next_f       = rf.f;
    rf.next_bc      = rf.bc;
    rf.next_de      = rf.de;
    rf.next_hl      = rf.hl;
    rf.we           = 1'b0;
    case (state)
      ST_FETCH: begin
        next_pc = pc + 24'h000001;
        if (mem_rdata == PFX_SHORT) begin
          next_pfx_short = 1'b1;
          next_pfx_long  = 1'b0;
        end else if (mem_rdata == PFX_LONG) begin
          next_pfx_long  = 1'b1;
          next_pfx_short = 1'b0;
        end else if (mem_rdata == PFX_FIRST || mem_rdata == PFX_SECOND) begin
          next_idx_second = (mem_rdata == PFX_SECOND);
          next_state      = ST_INDEX;
        end else if (mem_rdata == PFX_EXT) begin
          next_state = ST_EXT;
        end else if (mem_rdata == OP_OR_MEM) begin
          next_op_addr = rf.hl;
          next_state   = ST_OPND;
        end else if (mem_rdata == OP_OR_IMM) begin
          next_state = ST_IMM;
        end else if (mem_rdata[7:3] == OP_OR_REG && mem_rdata[2:0] != SEL_MEM) begin
          res       = rf.a | reg_operand;
          rf.next_a = res;
          rf.next_f = or_flags(rf.f, res);
          rf.we     = 1'b1;
          finish    = 1'b1;
        end else begin
          // Idle opcode, and anything not decoded here, only moves the program counter
          finish = 1'b1;
        end
      end
      ST_INDEX: begin
        next_pc = pc + 24'h000001;
        if (mem_rdata == OP_OR_HI || mem_rdata == OP_OR_LO) begin
          res       = rf.a | ((mem_rdata == OP_OR_HI) ? idx_reg[15:8] : idx_reg[7:0]);
          rf.next_a = res;
          rf.next_f = or_flags(rf.f, res);
          rf.we     = 1'b1;
          finish    = 1'b1;
        end else if (mem_rdata == OP_OR_MEM) begin
          next_state = ST_DISP;
        end else begin
          finish = 1'b1;
        end
      end
      ST_DISP: begin
        next_pc      = pc + 24'h000001;
        next_op_addr = wide ? (idx_reg + {{16{mem_rdata[7]}}, mem_rdata})
                            : {idx_reg[23:16], idx_reg[15:0] + {{8{mem_rdata[7]}}, mem_rdata}};
        next_state   = ST_OPND;
      end
      ST_OPND, ST_IMM: begin
        if (state == ST_IMM) begin
          next_pc = pc + 24'h000001;
        end
        res       = rf.a | mem_rdata;
        rf.next_a = res;
        rf.next_f = or_flags(rf.f, res);
        rf.we     = 1'b1;
        finish    = 1'b1;
      end
      ST_EXT: begin
        next_pc    = pc + 24'h000001;
        next_state = ST_BLK_READ;
        case (mem_rdata)
          OP_DUAL:   next_blk = BLK_DUAL;
          OP_PZ:     next_blk = BLK_PZ;
          OP_PZ_REP: next_blk = BLK_PZ_REP;
          OP_REP:    next_blk = BLK_REP;
          default: begin
            next_state = ST_FETCH;
            finish     = 1'b1;
          end
        endcase
      end
      ST_BLK_READ: begin
        next_xfer     = mem_rdata;
        next_io_wdata = mem_rdata;
        next_io_wr    = 1'b1;
        next_state    = ST_BLK_WRITE;
        case (blk)
          BLK_DUAL:          next_io_addr = {IO_UPPER, rf.de[15:0]};
          BLK_PZ, BLK_PZ_REP: next_io_addr = {IO_UPPER, 8'h00, rf.bc[7:0]};
          default:           next_io_addr = {IO_UPPER, rf.bc[15:0]};
        endcase
      end
      ST_BLK_WRITE: begin
        next_state = ST_BLK_STEP;
      end
      ST_BLK_STEP: begin
        rf.we      = 1'b1;
        rf.next_hl = dec_ptr(rf.hl, wide);
        rf.next_f[FLAG_N] = xfer[7];
        next_state = ST_FETCH;
        case (blk)
          BLK_DUAL: begin
            rf.next_bc = bc_dec;
            rf.next_de = dec_ptr(rf.de, wide);
            rf.next_f[FLAG_Z] = wide ? (bc_dec == 24'h000000) : (bc_dec[15:0] == 16'h0000);
            if (rf.next_f[FLAG_Z] == 1'b0) begin
              next_state = ST_BLK_READ;
            end
          end
          BLK_PZ, BLK_PZ_REP: begin
            rf.next_bc = {rf.bc[23:16], b_dec, c_dec};
            // Flags left undefined for these are simply kept
            rf.next_f[FLAG_Z] = (b_dec == 8'h00);
            if (blk == BLK_PZ_REP && b_dec != 8'h00) begin
              next_state = ST_BLK_READ;
            end
          end
          default: begin
            rf.next_bc = {rf.bc[23:16], b_dec, rf.bc[7:0]};
            rf.next_f[FLAG_Z] = (b_dec == 8'h00);
            if (b_dec != 8'h00) begin
              next_state = ST_BLK_READ;
            end
          end
        endcase
        finish = (next_state == ST_FETCH);
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
    if (finish) begin
      // Prefixes live for one instruction only
      next_state     = ST_FETCH;
      next_pfx_short = 1'b0;
      next_pfx_long  = 1'b0;
    end
    next_instr_done = finish;
    // Memory is read asynchronously at the registered address, one byte per cycle
    case (next_state)
      ST_OPND:      next_mem_addr = next_op_addr;
      ST_BLK_READ:  next_mem_addr = rf.next_hl;
      default:      next_mem_addr = next_pc;
    endcase
    next_mem_rd = (next_state != ST_BLK_WRITE) && (next_state != ST_BLK_STEP);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= ST_FETCH;
      blk        <= BLK_DUAL;
      pfx_short  <= 1'b0;
      pfx_long   <= 1'b0;
      idx_second <= 1'b0;
      op_addr    <= RST_PAIR;
      xfer       <= RST_BYTE;
      pc         <= RST_PC;
      mem_addr   <= RST_PC;
      mem_rd     <= 1'b1;
      io_addr    <= RST_PAIR;
      io_wdata   <= RST_BYTE;
      io_wr      <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      state      <= next_state;
      blk        <= next_blk;
      pfx_short  <= next_pfx_short;
      pfx_long   <= next_pfx_long;
      idx_second <= next_idx_second;
      op_addr    <= next_op_addr;
      xfer       <= next_xfer;
      pc         <= next_pc;
      mem_addr   <= next_mem_addr;
      mem_rd     <= next_mem_rd;
      io_addr    <= next_io_addr;
      io_wdata   <= next_io_wdata;
      io_wr      <= next_io_wr;
      instr_done <= next_instr_done;
    end
  end

  // Sampled reset keeps the release edge, whose fetch has not run yet, out of antecedents
  a_idle_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && state == ST_FETCH && mem_rdata == OP_IDLE)
      |=> instr_done && $stable(flags) && pc == $past(pc) + 24'h000001)
    else $error("idle instruction not one cycle or changed flags");

  a_or_mem_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_OPND)
      |=> instr_done && acc == $past(acc | mem_rdata) && !flags[FLAG_H]
          && !flags[FLAG_N] && !flags[FLAG_C] && flags[FLAG_PV] == ~(^acc))
    else $error("memory OR result or flags wrong");

  a_or_reg_single: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && state == ST_FETCH && mem_rdata == 8'hb0)
      |=> instr_done && acc == $past(acc | rf.bc[15:8]) && flags[FLAG_Z] == (acc == 8'h00))
    else $error("register OR not done in one cycle");

  a_or_mem_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && state == ST_FETCH && mem_rdata == OP_OR_MEM && !pfx_short && !pfx_long)
      |=> !instr_done ##1 instr_done)
    else $error("memory OR not two cycles");

  a_prefix_extra: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && state == ST_FETCH && mem_rdata == PFX_SHORT)
      |=> state == ST_FETCH && !instr_done && !wide && mem_addr == $past(pc) + 24'h000001)
    else $error("short prefix not taken as an extra cycle");

  a_blk_io_write: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_BLK_READ)
      |=> io_wr && io_wdata == $past(mem_rdata) ##1 !io_wr ##1 !io_wr)
    else $error("block output byte not written once");

  a_page0_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_BLK_READ && (blk == BLK_PZ || blk == BLK_PZ_REP))
      |=> io_addr[15:8] == 8'h00 && io_addr[7:0] == $past(rf.bc[7:0]))
    else $error("page-zero I/O address wrong");

  a_rep_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_BLK_STEP && blk == BLK_REP)
      |=> flags[FLAG_Z] == ($past(rf.bc[15:8]) == 8'h01) && $stable(flags[FLAG_C])
          && rf.bc[15:8] == $past(rf.bc[15:8]) - 8'h01)
    else $error("repeating output Z flag or count wrong");

  a_dual_repeat: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_BLK_STEP && blk == BLK_DUAL)
      |=> (flags[FLAG_Z] ? (state == ST_FETCH && instr_done) : (state == ST_BLK_READ)))
    else $error("dual-decrement did not repeat until count_pair ran out");

  a_single_pz_ends: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_BLK_STEP && blk == BLK_PZ)
      |=> instr_done && state == ST_FETCH && rf.hl == dec_ptr($past(rf.hl), $past(wide)))
    else $error("single page-zero output did not end after one byte");

endmodule : logic_or_and_block_output_exec

// file: reg_store.sv
// Working registers of the core: accumulator, flags and the multibyte pairs
`timescale 1ns/1ps
module reg_store
  import exec_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  regs_if.store     rf
);

  // Index registers are only read here; nothing loads them, so they hold their reset value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rf.a  <= RST_BYTE;
      rf.f  <= RST_BYTE;
      rf.bc <= RST_PAIR;
      rf.de <= RST_PAIR;
      rf.hl <= RST_PAIR;
      rf.ix <= RST_PAIR;
      rf.iy <= RST_PAIR;
    end else if (rf.we) begin
      rf.a  <= rf.next_a;
      rf.f  <= rf.next_f;
      rf.bc <= rf.next_bc;
      rf.de <= rf.next_de;
      rf.hl <= rf.next_hl;
    end
  end

endmodule : reg_store

// file: regs_if.sv
// Register file carrier between the executor and its register store
`timescale 1ns/1ps
interface regs_if;
  logic [7:0]  a;
  logic [7:0]  f;
  logic [23:0] bc;
  logic [23:0] de;
  logic [23:0] hl;
  logic [23:0] ix;
  logic [23:0] iy;
  logic [7:0]  next_a;
  logic [7:0]  next_f;
  logic [23:0] next_bc;
  logic [23:0] next_de;
  logic [23:0] next_hl;
  logic        we;

  modport core  (input a, f, bc, de, hl, ix, iy,
                 output next_a, next_f, next_bc, next_de, next_hl, we);
  modport store (output a, f, bc, de, hl, ix, iy,
                 input next_a, next_f, next_bc, next_de, next_hl, we);
endinterface : regs_if

// file: tb_logic_or_and_block_output_exec.sv
// Self-checking testbench of the OR / block output executor
`timescale 1ns/1ps
`define CHK(what, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", what, e, g); \
    end \
  end
module tb_logic_or_and_block_output_exec;
  import exec_pkg::*;
  typedef struct {logic [7:0] pfx; logic [7:0] x; logic [7:0] op; logic [7:0] arg;} ins_type;

  logic        clk;
  logic        sys_rst;
  logic        long_address_mode;
  logic [7:0]  mem_rdata;
  logic [23:0] mem_addr;
  logic        mem_rd;
  logic [23:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        instr_done;
  logic [23:0] pc;
  logic [7:0]  acc;
  logic [7:0]  flags;
  int          n_mismatch;
  int          compares;
  int          cycles;
  int          p;
  int          ecyc;
  logic [31:0] rng;
  logic        lam;
  logic [7:0]  ea;
  logic [7:0]  ef;
  logic [7:0]  mask;
  logic [23:0] bc;
  logic [23:0] de;
  logic [23:0] hl;
  logic [23:0] eq [$];
  ins_type     prog_q [$];

  logic_or_and_block_output_exec dut (
    .clk(clk), .sys_rst(sys_rst), .long_address_mode(long_address_mode),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .instr_done(instr_done), .pc(pc), .acc(acc),
    .flags(flags));
  io_mem_model u_mem (
    .clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr));

  always #25 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Short pointers wrap in the low 16 bits and keep their upper byte
  function automatic logic [23:0] dec(input logic [23:0] v, input logic w);
    return w ? v - 24'h000001 : {v[23:16], v[15:0] - 16'h0001};
  endfunction : dec

  task automatic emit(input logic [7:0] v);
    u_mem.prog[p] = v;
    p++;
  endtask : emit

  task automatic add(input logic [7:0] pf, input logic [7:0] x, input logic [7:0] op,
                     input logic [7:0] arg);
    prog_q.push_back('{pf, x, op, arg});
    if (pf != 8'h00)
      emit(pf);
    if (x != 8'h00)
      emit(x);
    emit(op);
    if (op == OP_OR_IMM || (op == OP_OR_MEM && x != 8'h00 && x != PFX_EXT))
      emit(arg);
  endtask : add

  task automatic model(input ins_type t);
    logic       w;
    logic       z;
    logic       orop;
    logic [7:0] v;
    logic [7:0] r;
    int         it;
    w = (t.pfx == PFX_LONG) || (t.pfx != PFX_SHORT && lam);
    mask = 8'hff;
    ecyc = (t.pfx != 8'h00) ? 1 : 0;
    v = 8'h00;
    orop = 1'b1;
    if (t.x == PFX_EXT) begin
      it = 0;
      do begin
        r = u_mem.rd(hl);
        case (t.op)
          OP_DUAL: eq.push_back({de[15:0], r});
          OP_REP:  eq.push_back({bc[15:0], r});
          default: eq.push_back({8'h00, bc[7:0], r});
        endcase
        if (t.op == OP_DUAL) begin
          bc = dec(bc, w);
          de = dec(de, w);
          z = w ? (bc == 24'h0) : (bc[15:0] == 16'h0);
        end else begin
          bc[15:8] = bc[15:8] - 8'h01;
          if (t.op != OP_REP)
            bc[7:0] = bc[7:0] - 8'h01;
          z = (bc[15:8] == 8'h00);
        end
        hl = dec(hl, w);
        ef[FLAG_Z] = z;
        ef[FLAG_N] = r[7];
        it++;
      end while (t.op != OP_PZ && !z);
      ecyc += (t.op == OP_PZ) ? 5 : 2 + 3 * it;
      if (t.op == OP_PZ || t.op == OP_PZ_REP)
        mask = 8'h42;
      orop = 1'b0;
    end else if (t.op == OP_IDLE) begin
      orop = 1'b0;
      ecyc += 1;
    end else if (t.op == OP_OR_IMM) begin
      v = t.arg;
      ecyc += 2;
    end else if (t.x != 8'h00 && t.op == OP_OR_MEM) begin
      v = u_mem.rd(w ? {{16{t.arg[7]}}, t.arg} : {8'h00, {8{t.arg[7]}}, t.arg});
      ecyc += 4;
    end else if (t.x != 8'h00) begin
      // Index registers stay zero out of reset
      ecyc += 2;
    end else if (t.op == OP_OR_MEM) begin
      v = u_mem.rd(hl);
      ecyc += 2;
    end else begin
      case (t.op[2:0])
        SEL_B:   v = bc[15:8];
        SEL_C:   v = bc[7:0];
        SEL_D:   v = de[15:8];
        SEL_E:   v = de[7:0];
        SEL_H:   v = hl[15:8];
        SEL_L:   v = hl[7:0];
        default: v = ea;
      endcase
      ecyc += 1;
    end
    if (orop) begin
      ea = ea | v;
      ef = {ea[7], ea == 8'h00, ef[5], 1'b0, ef[3], ~^ea, 2'b00};
    end
  endtask : model

  task automatic check(input ins_type t, input logic timed);
    int          c;
    logic [23:0] e;
    logic [23:0] g;
    // Mode changes only between instructions; a fetch cycle never looks at it
    rng = xs(rng);
    lam = rng[4];
    long_address_mode <= lam;
    model(t);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (instr_done !== 1'b1 && c < 2000);
    if (timed)
      `CHK("cycles", ecyc, c)
    `CHK("acc", ea, acc)
    `CHK("flags", ef & mask, flags & mask)
    `CHK("io count", eq.size(), u_mem.io_q.size())
    while (eq.size() > 0 && u_mem.io_q.size() > 0) begin
      e = eq.pop_front();
      g = u_mem.io_q.pop_front();
      `CHK("io addr and data", e, g)
    end
    eq.delete();
    u_mem.io_q.delete();
  endtask : check

  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Longest run is three block loops of about 770 cycles each
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    long_address_mode = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    p = 0;
    rng = 32'd89971;
    ea = 8'h00;
    ef = 8'h00;
    bc = 24'h0;
    de = 24'h0;
    hl = 24'h0;
    // Cleared in the loader's own process so the program cannot be wiped at start-up
    foreach (u_mem.prog[i])
      u_mem.prog[i] = 8'h00;
    add(8'h00, 8'h00, OP_IDLE, 8'h00);
    add(8'h00, 8'h00, OP_OR_IMM, 8'h00);
    add(8'h00, 8'h00, OP_OR_MEM, 8'h00);
    add(PFX_SHORT, 8'h00, OP_OR_MEM, 8'h00);
    add(8'h00, PFX_FIRST, OP_OR_HI, 8'h00);
    add(8'h00, PFX_SECOND, OP_OR_LO, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_A}, 8'h00);
    add(PFX_LONG, PFX_EXT, OP_PZ, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_D}, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_E}, 8'h00);
    add(8'h00, PFX_EXT, OP_PZ, 8'h00);
    // Single-bit immediates keep the accumulator from saturating at once
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      add(8'h00, 8'h00, OP_OR_IMM, 8'h01 << rng[2:0]);
    end
    rng = xs(rng);
    add(8'h00, PFX_FIRST, OP_OR_MEM, rng[7:0]);
    rng = xs(rng);
    add(PFX_LONG, PFX_SECOND, OP_OR_MEM, rng[7:0]);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_B}, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_C}, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_H}, 8'h00);
    add(8'h00, 8'h00, {OP_OR_REG, SEL_L}, 8'h00);
    add(8'h00, PFX_EXT, OP_REP, 8'h00);
    add(8'h00, PFX_EXT, OP_PZ_REP, 8'h00);
    add(8'h00, PFX_EXT, OP_DUAL, 8'h00);
    add(8'h00, 8'h00, OP_IDLE, 8'h00);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (prog_q[i])
      check(prog_q[i], i > 0);
    `CHK("pc", 24'(p), pc)
    finish_test();
  end
endmodule : tb_logic_or_and_block_output_exec
